// ### hw/fcp_top.sv
// Purpose: four channel 8-bit pulse width modulator with ahb-lite regs
// Assumes: single clock hclk, special mode flag arrives from a pin
// Notes: reads take one wait state, writes none
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
module fcp_top #(
    parameter int NCH = 4,
    parameter int CLKA_TAP = 0,
    parameter int CLKB_TAP = 0
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // chip mode pin
    input wire logic special_mode_flag,
    // port pins
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe
);
    // true when a prescale bit range is all ones
    function automatic logic tap_hit(input logic [6:0] c, input int t);
        logic [6:0] m;
        m = 7'((1 << t) - 1);
        tap_hit = (c & m) == m;
    endfunction : tap_hit

    // pwm level from counter, duty, period, polarity and count direction
    function automatic logic pwm_lvl(input logic [7:0] c,
        input logic [7:0] d, input logic [7:0] p, input logic pol,
        input logic dn);
        if (d == fcp_pkg::DUTY_FULL && p != fcp_pkg::ZERO8) begin
            pwm_lvl = ~pol;
        end else if (d >= p) begin
            pwm_lvl = pol;
        end else if (dn) begin
            // falling side toggles back on the duty match itself
            pwm_lvl = pol ^ (c > d);
        end else begin
            pwm_lvl = pol ^ (c >= d);
        end
    endfunction : pwm_lvl

    // bus tracking
    fcp_pkg::fcp_bus_type bus_q;
    logic [7:0] adr_q;
    logic [31:0] rdata_q;
    logic ready_q;
    // mode pin synchroniser
    logic special_mode_flag_s1_q, special_mode_flag_q;
    // software registers
    logic [3:0] sel_q, pol_q, en_q, dir_q;
    logic center_q;
    logic [2:0] tst_q;
    logic [6:0] pres_q;
    logic [7:0] sdiv_q [2];
    logic [7:0] scnt_q [2];
    logic [1:0] shalf_q;
    // per channel state
    logic [7:0] cnt_q [NCH];
    logic [7:0] perb_q [NCH];
    logic [7:0] pera_q [NCH];
    logic [7:0] dtyb_q [NCH];
    logic [7:0] dtya_q [NCH];
    logic [NCH-1:0] down_q, run_q;
    logic [3:0] out_q, oe_q;
    // decoded strobes and clock ticks
    logic take, wr_now;
    logic any_en, tick_a, tick_b;
    logic [1:0] src_tick, s_tick;
    logic [NCH-1:0] ch_src, cnt_wr, per_wr, dty_wr;

    assign take = hsel && hready && (htrans == fcp_pkg::HTRANS_NONSEQ ||
        htrans == fcp_pkg::HTRANS_SEQ);
    assign wr_now = (bus_q == fcp_pkg::BUS_WRITE);
    assign any_en = |en_q;
    assign tick_a = any_en && tap_hit(pres_q, CLKA_TAP);
    assign tick_b = any_en && tap_hit(pres_q, CLKB_TAP);
    assign src_tick = {tick_b, tick_a};

    // scaled clock: divide by divisor+1, then by two
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            s_tick[s] = src_tick[s] && scnt_q[s] == fcp_pkg::ZERO8 &&
                shalf_q[s];
        end
    end

    // channel strobes and selected clocks
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            cnt_wr[c] = wr_now && adr_q == 8'(fcp_pkg::ADR_CNT0 + 4*c);
            per_wr[c] = wr_now && adr_q == 8'(fcp_pkg::ADR_PER0 + 4*c);
            dty_wr[c] = wr_now && adr_q == 8'(fcp_pkg::ADR_DTY0 + 4*c);
            // channels 0,1 use clock a side, 2,3 clock b side
            ch_src[c] = sel_q[c] ? s_tick[c/2] : src_tick[c/2];
        end
    end

    // mode pin passes two flops first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            special_mode_flag_s1_q <= 1'b0;
            special_mode_flag_q <= 1'b0;
        end else begin
            special_mode_flag_s1_q <= special_mode_flag;
            special_mode_flag_q <= special_mode_flag_s1_q;
        end
    end

    // bus phase tracking; reads get one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_q <= fcp_pkg::BUS_IDLE;
            adr_q <= fcp_pkg::ZERO8;
            ready_q <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0; // always okay
            case (bus_q)
                fcp_pkg::BUS_RDWAIT: begin
                    bus_q <= fcp_pkg::BUS_IDLE;
                    ready_q <= 1'b1;
                end
                default: begin
                    if (take) begin
                        adr_q <= haddr[7:0];
                        bus_q <= hwrite ? fcp_pkg::BUS_WRITE
                                        : fcp_pkg::BUS_RDWAIT;
                        ready_q <= hwrite;
                    end else begin
                        bus_q <= fcp_pkg::BUS_IDLE;
                    end
                end
            endcase
        end
    end
    assign hreadyout = ready_q;

    // read data, captured in the wait cycle; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_q == fcp_pkg::BUS_RDWAIT) begin
            rdata_q <= 32'h0000_0000;
            case (adr_q)
                fcp_pkg::ADR_CTRL:
                    rdata_q[8:0] <= {center_q, pol_q, sel_q};
                fcp_pkg::ADR_ENABLE: rdata_q[3:0] <= en_q;
                fcp_pkg::ADR_PRESCALE: rdata_q[6:0] <= pres_q;
                fcp_pkg::ADR_SDIV0: rdata_q[7:0] <= sdiv_q[0];
                fcp_pkg::ADR_SCNT0: rdata_q[7:0] <= scnt_q[0];
                fcp_pkg::ADR_SDIV1: rdata_q[7:0] <= sdiv_q[1];
                fcp_pkg::ADR_SCNT1: rdata_q[7:0] <= scnt_q[1];
                fcp_pkg::ADR_TEST: rdata_q[2:0] <= tst_q;
                fcp_pkg::ADR_DIR: rdata_q[3:0] <= dir_q;
                default: begin
                    for (int c = 0; c < NCH; c++) begin
                        // plain read, no side effect on the count
                        if (adr_q == 8'(fcp_pkg::ADR_CNT0 + 4*c))
                            rdata_q[7:0] <= cnt_q[c];
                        if (adr_q == 8'(fcp_pkg::ADR_PER0 + 4*c))
                            rdata_q[7:0] <= perb_q[c];
                        if (adr_q == 8'(fcp_pkg::ADR_DTY0 + 4*c))
                            rdata_q[7:0] <= dtyb_q[c];
                    end
                end
            endcase
        end
    end
    assign hrdata = rdata_q;

    // control, enable and direction registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= 4'h0;
            pol_q <= 4'h0;
            center_q <= 1'b0;
            en_q <= 4'h0;
            dir_q <= 4'h0;
        end else if (wr_now) begin
            case (adr_q)
                fcp_pkg::ADR_CTRL: begin
                    sel_q <= hwdata[fcp_pkg::CTRL_SEL_LSB +: 4];
                    pol_q <= hwdata[fcp_pkg::CTRL_POL_LSB +: 4];
                    center_q <= hwdata[fcp_pkg::CTRL_CENTER];
                end
                fcp_pkg::ADR_ENABLE: en_q <= hwdata[3:0];
                fcp_pkg::ADR_DIR: dir_q <= hwdata[3:0];
                default: ;
            endcase
        end
    end

    // test bits: written only in special mode, cleared outside it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tst_q <= 3'h0;
        end else if (!special_mode_flag_q) begin
            tst_q <= 3'h0;
        end else if (wr_now && adr_q == fcp_pkg::ADR_TEST) begin
            tst_q <= hwdata[2:0];
        end
    end

    // shared prescale counter, stopped when every channel is off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pres_q <= fcp_pkg::ZERO7;
        end else if (wr_now && special_mode_flag_q && adr_q == fcp_pkg::ADR_PRESCALE) begin
            pres_q <= hwdata[6:0];
        end else if (any_en) begin
            pres_q <= pres_q + fcp_pkg::ONE7;
        end
    end

    // scale divisors and their down-counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int s = 0; s < 2; s++) begin
                sdiv_q[s] <= fcp_pkg::ZERO8;
                scnt_q[s] <= fcp_pkg::ZERO8;
            end
            shalf_q <= 2'b00;
        end else begin
            for (int s = 0; s < 2; s++) begin
                if (wr_now && adr_q == (s == 0 ? fcp_pkg::ADR_SDIV0
                                                : fcp_pkg::ADR_SDIV1)) begin
                    sdiv_q[s] <= hwdata[7:0];
                    // immediate load unless inhibited in special mode
                    if (!(special_mode_flag_q && tst_q[fcp_pkg::TST_SLD])) begin
                        scnt_q[s] <= hwdata[7:0];
                        shalf_q[s] <= 1'b0;
                    end
                end else if (src_tick[s]) begin
                    if (scnt_q[s] == fcp_pkg::ZERO8) begin
                        scnt_q[s] <= sdiv_q[s];
                        shalf_q[s] <= ~shalf_q[s];
                    end else begin
                        scnt_q[s] <= scnt_q[s] - fcp_pkg::ONE8;
                    end
                end
            end
        end
    end

    // run gate rises with enable only on a source clock tick, clears at once when enable drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (ch_src[c] || !en_q[c])
                    run_q[c] <= en_q[c];
            end
        end
    end

    // channel counters with buffered period and duty
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < NCH; c++) begin
                cnt_q[c] <= fcp_pkg::ZERO8;
                perb_q[c] <= fcp_pkg::ZERO8;
                pera_q[c] <= fcp_pkg::ZERO8;
                dtyb_q[c] <= fcp_pkg::ZERO8;
                dtya_q[c] <= fcp_pkg::ZERO8;
            end
            down_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (per_wr[c]) begin
                    perb_q[c] <= hwdata[7:0];
                    if (!en_q[c])
                        pera_q[c] <= hwdata[7:0];
                end
                if (dty_wr[c]) begin
                    dtyb_q[c] <= hwdata[7:0];
                    if (!en_q[c])
                        dtya_q[c] <= hwdata[7:0];
                end
                if (!en_q[c] && !per_wr[c] && !dty_wr[c]) begin
                    // disabling takes up any pending buffer
                    pera_q[c] <= perb_q[c];
                    dtya_q[c] <= dtyb_q[c];
                end
                if (cnt_wr[c]) begin
                    if (!(special_mode_flag_q && tst_q[fcp_pkg::TST_CWR])) begin
                        cnt_q[c] <= fcp_pkg::ZERO8;
                        down_q[c] <= 1'b0;
                    end
                    pera_q[c] <= perb_q[c];
                    dtya_q[c] <= dtyb_q[c];
                end else if (run_q[c] && ch_src[c]) begin
                    // counting resumes from the held value
                    if (!center_q) begin
                        if (cnt_q[c] == pera_q[c] &&
                            !(special_mode_flag_q && tst_q[fcp_pkg::TST_PMR])) begin
                            cnt_q[c] <= fcp_pkg::ZERO8;
                            pera_q[c] <= perb_q[c];
                            dtya_q[c] <= dtyb_q[c];
                        end else begin
                            cnt_q[c] <= cnt_q[c] + fcp_pkg::ONE8;
                        end
                    end else if (!down_q[c]) begin
                        if (cnt_q[c] >= pera_q[c]) begin
                            down_q[c] <= 1'b1;
                            if (cnt_q[c] != fcp_pkg::ZERO8)
                                cnt_q[c] <= cnt_q[c] - fcp_pkg::ONE8;
                        end else begin
                            cnt_q[c] <= cnt_q[c] + fcp_pkg::ONE8;
                        end
                    end else begin
                        if (cnt_q[c] <= fcp_pkg::ONE8) begin
                            // rollover at the bottom, 2*per ticks total
                            cnt_q[c] <= fcp_pkg::ZERO8;
                            down_q[c] <= 1'b0;
                            pera_q[c] <= perb_q[c];
                            dtya_q[c] <= dtyb_q[c];
                        end else begin
                            cnt_q[c] <= cnt_q[c] - fcp_pkg::ONE8;
                        end
                    end
                end
            end
        end
    end

    // pin drivers: enable overrides direction without changing it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_q <= 4'h0;
            oe_q <= 4'h0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                oe_q[c] <= en_q[c] | dir_q[c];
                out_q[c] <= run_q[c] ? pwm_lvl(cnt_q[c], dtya_q[c],
                    pera_q[c], pol_q[c], center_q && down_q[c])
                    : 1'b0;
            end
        end
    end
    assign pin_out = out_q;
    assign pin_oe = oe_q;
endmodule : fcp_top

// ### include/fcp_pkg.sv
// Purpose: constants for the four channel pwm core
// Assumes: ahb-lite register bus, one word per register
// Notes: offsets are byte addresses
package fcp_pkg;
    // register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_ENABLE = 8'h04;
    localparam logic [7:0] ADR_PRESCALE = 8'h08;
    localparam logic [7:0] ADR_SDIV0 = 8'h0C;
    localparam logic [7:0] ADR_SCNT0 = 8'h10;
    localparam logic [7:0] ADR_SDIV1 = 8'h14;
    localparam logic [7:0] ADR_SCNT1 = 8'h18;
    localparam logic [7:0] ADR_TEST = 8'h1C;
    localparam logic [7:0] ADR_DIR = 8'h20;
    localparam logic [7:0] ADR_CNT0 = 8'h40;
    localparam logic [7:0] ADR_PER0 = 8'h50;
    localparam logic [7:0] ADR_DTY0 = 8'h60;
    // control register fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_POL_LSB = 4;
    localparam int CTRL_CENTER = 8;
    // test register fields
    localparam int TST_CWR = 0;
    localparam int TST_PMR = 1;
    localparam int TST_SLD = 2;
    // values
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] ONE8 = 8'h01;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [6:0] ZERO7 = 7'h00;
    localparam logic [6:0] ONE7 = 7'h01;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    // bus answer state
    typedef enum logic [1:0] {
        BUS_IDLE, BUS_RDWAIT, BUS_WRITE
    } fcp_bus_type;
endpackage : fcp_pkg

// ### verif/fcp_chk.sv
// Purpose: port checks for the pwm core
// Assumes: hready is fed back from hreadyout
// Notes: enable and direction are shadowed from bus writes
module fcp_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // mode and pins
    input wire logic special_mode_flag,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire go = hsel & hready & htrans[1]; // transfer taken
    wire [7:0] a8 = haddr[7:0]; // decoded address bits
    logic wr_q; // write data phase pending
    logic [7:0] wa_q; // its address
    logic [3:0] en_q; // shadow of channel enables
    logic [3:0] dir_q; // shadow of port direction
    wire [3:0] oe_want = en_q | dir_q; // pins that must drive
    // carry the address phase into the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else if (hready) begin
            wr_q <= go & hwrite;
            wa_q <= a8;
        end
    end
    // shadows change when the write data phase closes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q <= 4'h0;
            dir_q <= 4'h0;
        end else if (wr_q && hready) begin
            if (wa_q == fcp_pkg::ADR_ENABLE) en_q <= hwdata[3:0];
            if (wa_q == fcp_pkg::ADR_DIR) dir_q <= hwdata[3:0];
        end
    end
    sequence rd_go;
        go && !hwrite;
    endsequence
    sequence rd_ans;
        !hreadyout ##1 hreadyout;
    endsequence
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("slave gave an error response");
    AST_READ_WAIT: assert property (rd_go |=> rd_ans)
        else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (go && hwrite |=> hreadyout)
        else $error("write was stalled");
    AST_HIGH_ZERO: assert property (rd_go |-> ##2 hrdata[31:9] == 23'h0)
        else $error("upper read bits not zero");
    AST_OE_FOLLOW: assert property (pin_oe == $past(oe_want))
        else $error("pin direction wrong");
    AST_OFF_LOW: assert property ((pin_out & ~en_q & ~$past(en_q)
        & ~$past(en_q, 2)) == 4'h0)
        else $error("disabled channel drives high");
    AST_EN_READ: assert property (
        rd_go ##0 (a8 == fcp_pkg::ADR_ENABLE)
        |-> ##2 hrdata == {28'h000_0000, en_q})
        else $error("enable read back wrong");
    AST_DIR_READ: assert property (
        rd_go ##0 (a8 == fcp_pkg::ADR_DIR)
        |-> ##2 hrdata == {28'h000_0000, dir_q})
        else $error("direction read back wrong");
    AST_TEST_NORMAL: assert property (
        rd_go ##0 (a8 == fcp_pkg::ADR_TEST
        && !special_mode_flag && !$past(special_mode_flag)
        && !$past(special_mode_flag, 2)) |-> ##2 hrdata == 32'h0000_0000)
        else $error("test bits visible in normal mode");
endmodule : fcp_chk

bind fcp_top fcp_chk i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .special_mode_flag(special_mode_flag),
    .pin_out(pin_out), .pin_oe(pin_oe)
);

// ### verif/fcp_load.sv
// Purpose: external load on the four pwm pins
// Assumes: every pin has a pull-down resistor
// Notes: a released pin settles low
module fcp_load (
    // pins from the core
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // level seen at the load
    output logic [3:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // driven pins follow the core, released ones fall to the pull-down
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : 1'b0;
        end
    end
endmodule : fcp_load

// ### verif/fcp_top_test.sv
// Purpose: self-checking bench for the four channel pwm core
// Assumes: clock sources tick every hclk while any channel is enabled (taps at zero)
// Notes: waveforms are judged by high time over whole periods
module fcp_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0; // bus clock
    logic hresetn = 1'b0; // reset, active low
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic smode = 1'b0; // special mode pin
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] pin_level; // level at the load
    int bad_count = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h597c_7695; // xorshift state
    localparam logic [7:0] RW_ADR [4] = '{fcp_pkg::ADR_CTRL,
        fcp_pkg::ADR_SDIV0, fcp_pkg::ADR_SDIV1, fcp_pkg::ADR_DIR};
    fcp_top #(.NCH(4), .CLKA_TAP(0), .CLKB_TAP(0)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .special_mode_flag(smode), .pin_out(pin_out), .pin_oe(pin_oe)
    );
    fcp_load i_load (.pin_out(pin_out), .pin_oe(pin_oe),
        .pin_level(pin_level));
    always #4 hclk = ~hclk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // high cycles in one output period
    function automatic int hi_exp(int per, int dty, int pol, int cen);
        if (per == 0) return pol ? 4 : 0;
        if (dty == 255) return pol ? 0 : (cen ? 2 * per : per + 1);
        if (dty >= per) return pol ? (cen ? 2 * per : per + 1) : 0;
        if (cen) return pol ? 2 * dty : 2 * (per - dty);
        return pol ? dty : per + 1 - dty;
    endfunction : hi_exp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    // one single word transfer, waiting on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= fcp_pkg::HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        q = hrdata;
        if (n >= 50) bad_count++;
    endtask : bus
    task automatic bw(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : bw
    task automatic bc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, e);
    endtask : bc
    // main sequence
    initial begin
        int ch, cen, pol, sc, k, per, dty, win, hi;
        logic [7:0] a;
        logic [31:0] v;
        logic [31:0] m;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 29; i++) bc(8'(4 * i), 32'h0000_0000);
        bw(fcp_pkg::ADR_PRESCALE, 32'h0000_007f);
        bc(fcp_pkg::ADR_PRESCALE, 32'h0000_0000);
        bw(fcp_pkg::ADR_TEST, 32'h0000_0007);
        bc(fcp_pkg::ADR_TEST, 32'h0000_0000);
        bw(8'h24, rnd());
        bc(8'h24, 32'h0000_0000);
        // writable words read back masked, divisors preload scale counts
        for (int i = 0; i < 12; i++) begin
            a = (i < 4) ? RW_ADR[i] : 8'(8'h50 + 4 * (i - 4));
            m = (i == 0) ? 32'h0000_01ff : 32'h0000_00ff;
            m = (i == 3) ? 32'h0000_000f : m;
            v = rnd();
            bw(a, v);
            bc(a, v & m);
            if (i == 1 || i == 2) bc(a + 8'h04, v & 32'h0000_00ff);
        end
        // enables force pins out without touching the direction bits
        bw(fcp_pkg::ADR_DIR, 32'h0000_0005);
        bw(fcp_pkg::ADR_ENABLE, 32'h0000_0003);
        repeat (2) @(posedge hclk);
        check({28'h000_0000, pin_oe}, 32'h0000_0007);
        bc(fcp_pkg::ADR_DIR, 32'h0000_0005);
        bw(fcp_pkg::ADR_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        check({28'h000_0000, pin_oe}, 32'h0000_0005);
        // special mode opens the prescale and test words
        smode <= 1'b1;
        repeat (4) @(posedge hclk);
        bw(fcp_pkg::ADR_PRESCALE, 32'h0000_00aa);
        bw(fcp_pkg::ADR_TEST, 32'h0000_0005);
        repeat (5) @(posedge hclk);
        bc(fcp_pkg::ADR_PRESCALE, 32'h0000_002a);
        bc(fcp_pkg::ADR_TEST, 32'h0000_0005);
        // inhibited divisor write leaves the scale count alone
        bus(1'b0, fcp_pkg::ADR_SCNT0, 32'h0000_0000, v);
        bw(fcp_pkg::ADR_SDIV0, 32'h0000_0033);
        bc(fcp_pkg::ADR_SCNT0, v);
        // inhibited counter write keeps the count
        bus(1'b0, fcp_pkg::ADR_CNT0, 32'h0000_0000, v);
        bw(fcp_pkg::ADR_CNT0, rnd());
        bc(fcp_pkg::ADR_CNT0, v);
        // period match inhibit lets the count run past the period
        bw(fcp_pkg::ADR_TEST, 32'h0000_0002);
        bw(fcp_pkg::ADR_CTRL, 32'h0000_0000);
        bw(fcp_pkg::ADR_PER0, 32'h0000_0004);
        bw(fcp_pkg::ADR_CNT0, 32'h0000_0000);
        bw(fcp_pkg::ADR_ENABLE, 32'h0000_0001);
        repeat (20) @(posedge hclk);
        bw(fcp_pkg::ADR_ENABLE, 32'h0000_0000);
        bus(1'b0, fcp_pkg::ADR_CNT0, 32'h0000_0000, v);
        check(32'(v > 32'h0000_0004), 32'h0000_0001);
        smode <= 1'b0;
        repeat (4) @(posedge hclk);
        bc(fcp_pkg::ADR_TEST, 32'h0000_0000);
        bw(fcp_pkg::ADR_SDIV0, 32'h0000_0001);
        bw(fcp_pkg::ADR_SDIV1, 32'h0000_0001);
        // waveforms over alignments, polarities, clocks and bounds
        for (int i = 0; i < 16; i++) begin
            ch = i % 4;
            cen = (i / 4) % 2;
            pol = i / 8;
            sc = (i / 2) % 2;
            k = (i + i / 4) % 4;
            per = (k == 3) ? 0 : 4 + int'(rnd() % 32'd37);
            dty = (k == 3) ? int'(rnd() % 32'd256) : 255;
            if (k == 0) dty = 1 + int'(rnd() % 32'(per - 1));
            if (k == 1) dty = per + int'(rnd() % 32'(255 - per));
            win = (per == 0) ? 4 : (cen ? 2 * per : per + 1);
            win = win * (sc ? 4 : 1);
            a = 8'(4 * ch);
            bw(fcp_pkg::ADR_ENABLE, 32'h0000_0000);
            v = 32'((cen << 8) | (pol << (4 + ch)) | (sc << ch));
            bw(fcp_pkg::ADR_CTRL, v);
            bw(fcp_pkg::ADR_PER0 + a, 32'(per));
            bw(fcp_pkg::ADR_DTY0 + a, 32'(dty));
            bw(fcp_pkg::ADR_CNT0 + a, rnd());
            bc(fcp_pkg::ADR_CNT0 + a, 32'h0000_0000);
            bw(fcp_pkg::ADR_ENABLE, 32'(1 << ch));
            bus(1'b0, fcp_pkg::ADR_CNT0 + a, 32'h0000_0000, v);
            repeat (3 * win + 8) @(posedge hclk);
            hi = 0;
            repeat (2 * win) begin
                @(posedge hclk);
                if (pin_level[ch] === 1'b1) hi++;
            end
            v = 32'(2 * hi_exp(per, dty, pol, cen) * (sc ? 4 : 1));
            check(32'(hi), v);
        end
        stop_test();
    end
    // watchdog against a hung handshake
    initial begin
        #(8 * 90000);
        bad_count++;
        stop_test();
    end
endmodule : fcp_top_test
